// *** hdl/ltcc_consts.svh ***
// offsets, field positions, reset values and counts of the tx control block
// assumes inclusion by bare name from each design file that needs it
`ifndef LTCC_CONSTS_SVH
`define LTCC_CONSTS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define LTCC_TC_OFFSET 8'h04
`define LTCC_ST_OFFSET 8'h0F

// ------------------------------------------------------------
// reset values and write masks
// ------------------------------------------------------------
`define LTCC_TC_RESET 8'h00
`define LTCC_TC_WMASK 8'h37

// ------------------------------------------------------------
// status register bit positions
// ------------------------------------------------------------
`define LTCC_ST_ALARM 0
`define LTCC_ST_PEND 1

// ------------------------------------------------------------
// drive monitor: empty bit periods before the alarm
// ------------------------------------------------------------
`define LTCC_DMO_BITS 8'd128

`endif

// *** hdl/ltcc_mon.sv ***
// drive monitor: counts bit periods with no bipolar pulse on the rails
// assumes bit_tick is a one-cycle pulse per bit period, rails synchronous
`timescale 1ns/1ps
`include "ltcc_consts.svh"

module ltcc_mon
   import ltcc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // observed rails
   input wire logic bit_tick,
   input wire logic mon_plus,
   input wire logic mon_minus,
   // result
   output logic alarm
);
   ltcc_mon_st_t s_q, s_d;
   logic [7:0] cnt_inc;

   assign cnt_inc = s_q.cnt + 8'd1;

   // --------------------------------------------------------
   // pulse watch
   // --------------------------------------------------------
   // counter saturates at the threshold so a dead line holds the alarm
   always_comb
   begin
      s_d = s_q;
      if (bit_tick)
      begin
         if (mon_plus | mon_minus)
         begin
            s_d.cnt = 8'd0;
            s_d.alarm = 1'b0;
         end
         else if (s_q.cnt != `LTCC_DMO_BITS)
         begin
            s_d.cnt = cnt_inc;
            if (cnt_inc == `LTCC_DMO_BITS)
               s_d.alarm = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign alarm = s_q.alarm;

   // --------------------------------------------------------
   // checks
   // --------------------------------------------------------
   property p_alarm_run;
      @(posedge clk) disable iff (!reset_n)
      $rose(s_q.alarm) |-> $past(s_q.cnt) == 8'd127 && $past(bit_tick);
   endproperty
   a_alarm_run: assert property (p_alarm_run)
      else $error("alarm raised without a full empty run");

   property p_pulse_clears;
      @(posedge clk) disable iff (!reset_n)
      bit_tick && (mon_plus | mon_minus) |=> !s_q.alarm && s_q.cnt == 8'd0;
   endproperty
   a_pulse_clears: assert property (p_pulse_clears)
      else $error("pulse seen but alarm or count not cleared");
endmodule

// *** hdl/ltcc_pkg.sv ***
// types shared by the tx control block and its drive monitor
// assumes the constants header sits beside it
package ltcc_pkg;

   // ---------------------------------------------------------
   // register and bus carriers
   // ---------------------------------------------------------
   typedef enum logic {
      LTCC_MON_EXT = 1'b0,
      LTCC_MON_INT = 1'b1
   } ltcc_mon_src_t;

   // field layout of the transmit channel control register
   typedef struct packed {
      logic [1:0] rsv_hi;
      ltcc_mon_src_t mon_src;
      logic ins_err;
      logic rsv3;
      logic send_all_ones;
      logic sample_edge_rise;
      logic pulse_shaping;
   } ltcc_tc_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ltcc_bus_req_t;

   // ---------------------------------------------------------
   // module state
   // ---------------------------------------------------------
   typedef struct packed {
      ltcc_tc_t tc;
      logic [7:0] rd_data;
      logic clk_prev;
      logic alt;
      logic line_plus;
      logic line_minus;
      logic pend;
      logic inject;
      logic shape_en;
   } ltcc_top_st_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic alarm;
   } ltcc_mon_st_t;

endpackage

// *** hdl/ltcc_top.sv ***
// transmit channel control register with drive monitor and error insert
// assumes all pins synchronous to CLK; line clock pin is sampled, not a clock
`timescale 1ns/1ps
`include "ltcc_consts.svh"

module ltcc_top
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // register port
   input ltcc_pkg::ltcc_bus_req_t BUS_REQ,
   output logic [7:0] RD_DATA,
   // system side transmit data
   input wire logic TRANSMIT_LINE_CLOCK,
   input wire logic TRANSMIT_POSITIVE_DATA,
   input wire logic TRANSMIT_NEGATIVE_DATA,
   // line side
   output logic LINE_OUT_PLUS,
   output logic LINE_OUT_MINUS,
   input wire logic MONITOR_IN_PLUS,
   input wire logic MONITOR_IN_MINUS,
   // channel configuration from neighbouring registers
   input wire logic PRBS_GEN_EN,
   input wire logic PRBS_RX_EN,
   input wire logic E3_MODE,
   // controls and status out
   output logic PRBS_ERR_INJECT,
   output logic PULSE_SHAPE_EN,
   output logic DRIVE_MONITOR_ALARM
);
   import ltcc_pkg::*;

   // ---------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------
   function automatic logic hit(input logic [7:0] addr,
                                input logic [7:0] off);
      hit = (addr == off);
   endfunction

   ltcc_top_st_t s_q, s_d;
   ltcc_tc_t wr_val;
   logic [7:0] st_word;
   logic clk_rise, clk_fall, bit_tick, wr_tc, ins_edge, prbs_on;
   logic mon_plus, mon_minus, alarm;

   // ---------------------------------------------------------
   // line clock edges and write decode
   // ---------------------------------------------------------
   assign clk_rise = TRANSMIT_LINE_CLOCK & ~s_q.clk_prev;
   assign clk_fall = ~TRANSMIT_LINE_CLOCK & s_q.clk_prev;
   assign bit_tick = s_q.tc.sample_edge_rise ? clk_rise : clk_fall;
   assign wr_tc = BUS_REQ.wr && hit(BUS_REQ.addr, `LTCC_TC_OFFSET);
   assign wr_val = ltcc_tc_t'(BUS_REQ.wdata & `LTCC_TC_WMASK);
   // only a fresh rising write arms an error, a held 1 does not
   assign ins_edge = wr_tc && wr_val.ins_err && !s_q.tc.ins_err;
   assign prbs_on = PRBS_GEN_EN && PRBS_RX_EN;

   // ---------------------------------------------------------
   // monitor source select
   // ---------------------------------------------------------
   // internal mode taps the pad drivers, so open monitor pins do no harm
   assign mon_plus = (s_q.tc.mon_src == LTCC_MON_INT) ?
                     s_q.line_plus : MONITOR_IN_PLUS;
   assign mon_minus = (s_q.tc.mon_src == LTCC_MON_INT) ?
                      s_q.line_minus : MONITOR_IN_MINUS;

   ltcc_mon u_mon
   (
      .clk(CLK),
      .reset_n(RESET_N),
      .bit_tick(bit_tick),
      .mon_plus(mon_plus),
      .mon_minus(mon_minus),
      .alarm(alarm)
   );

   // status word: alarm and error-pending flags
   always_comb
   begin
      st_word = 8'h00;
      st_word[`LTCC_ST_ALARM] = alarm;
      st_word[`LTCC_ST_PEND] = s_q.pend;
   end

   // ---------------------------------------------------------
   // next state
   // ---------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.clk_prev = TRANSMIT_LINE_CLOCK;
      s_d.inject = 1'b0;
      s_d.rd_data = 8'h00;
      if (wr_tc)
         s_d.tc = wr_val;
      // line output, one symbol per selected clock edge
      if (bit_tick)
      begin
         if (s_q.tc.send_all_ones)
         begin
            s_d.line_plus = s_q.alt;
            s_d.line_minus = ~s_q.alt;
            s_d.alt = ~s_q.alt;
         end
         else
         begin
            s_d.line_plus = TRANSMIT_POSITIVE_DATA;
            s_d.line_minus = TRANSMIT_NEGATIVE_DATA;
         end
      end
      // error is handed to the generator on a bit boundary; a new arm
      // in the delivery cycle stays pending, so no edge is lost
      if (!prbs_on)
         s_d.pend = 1'b0;
      else if (bit_tick && s_q.pend)
      begin
         s_d.inject = 1'b1;
         s_d.pend = ins_edge;
      end
      else if (ins_edge)
         s_d.pend = 1'b1;
      s_d.shape_en = s_q.tc.pulse_shaping & ~E3_MODE;
      // read data stand only in the cycle after the strobe
      if (BUS_REQ.rd)
      begin
         if (hit(BUS_REQ.addr, `LTCC_TC_OFFSET))
            s_d.rd_data = s_q.tc;
         else if (hit(BUS_REQ.addr, `LTCC_ST_OFFSET))
            s_d.rd_data = st_word;
      end
   end

   // state register
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         s_q <= '0;
         s_q.tc <= ltcc_tc_t'(`LTCC_TC_RESET);
      end
      else
         s_q <= s_d;
   end

   // ---------------------------------------------------------
   // outputs
   // ---------------------------------------------------------
   assign RD_DATA = s_q.rd_data;
   assign LINE_OUT_PLUS = s_q.line_plus;
   assign LINE_OUT_MINUS = s_q.line_minus;
   assign PRBS_ERR_INJECT = s_q.inject;
   assign PULSE_SHAPE_EN = s_q.shape_en;
   assign DRIVE_MONITOR_ALARM = alarm;

   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   property p_ext_src;
      s_q.tc.mon_src == LTCC_MON_EXT && bit_tick &&
      (MONITOR_IN_PLUS | MONITOR_IN_MINUS) |=> !DRIVE_MONITOR_ALARM;
   endproperty
   a_ext_src: assert property (p_ext_src)
      else $error("external pulse did not clear alarm");

   property p_int_src;
      s_q.tc.mon_src == LTCC_MON_INT && bit_tick &&
      (LINE_OUT_PLUS | LINE_OUT_MINUS) |=> !DRIVE_MONITOR_ALARM;
   endproperty
   a_int_src: assert property (p_int_src)
      else $error("pad pulse did not clear alarm in internal mode");

   property p_alarm_cause;
      $rose(DRIVE_MONITOR_ALARM) |->
         $past(bit_tick) && !$past(mon_plus) && !$past(mon_minus);
   endproperty
   a_alarm_cause: assert property (p_alarm_cause)
      else $error("alarm rose without an empty bit period");

   // arming and delivery are separate steps, a bit boundary between them
   sequence s_armed;
      ins_edge && prbs_on;
   endsequence
   sequence s_due;
      s_q.pend && bit_tick && prbs_on;
   endsequence
   property p_ins_arm;
      s_armed |=> s_q.pend;
   endproperty
   a_ins_arm: assert property (p_ins_arm)
      else $error("fresh error insert write did not arm");

   // ticks are never back to back, so one pulse per armed error
   property p_ins_deliver;
      s_due |=> PRBS_ERR_INJECT ##1 !PRBS_ERR_INJECT;
   endproperty
   a_ins_deliver: assert property (p_ins_deliver)
      else $error("armed error not delivered once on next bit");

   property p_ins_gate;
      PRBS_ERR_INJECT |-> $past(prbs_on) && $past(bit_tick) &&
         $past(s_q.pend);
   endproperty
   a_ins_gate: assert property (p_ins_gate)
      else $error("error injected while PRBS not enabled");

   property p_rsv_zero;
      BUS_REQ.rd && hit(BUS_REQ.addr, `LTCC_TC_OFFSET) |=>
         (RD_DATA & ~`LTCC_TC_WMASK) == 8'h00;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("reserved bits read non-zero");

   property p_all_ones;
      bit_tick && s_q.tc.send_all_ones |=>
         LINE_OUT_PLUS != LINE_OUT_MINUS;
   endproperty
   a_all_ones: assert property (p_all_ones)
      else $error("all-ones mode sent an empty symbol");

   property p_sys_data;
      bit_tick && !s_q.tc.send_all_ones |=>
         LINE_OUT_PLUS == $past(TRANSMIT_POSITIVE_DATA) &&
         LINE_OUT_MINUS == $past(TRANSMIT_NEGATIVE_DATA);
   endproperty
   a_sys_data: assert property (p_sys_data)
      else $error("system data not passed to line");

   property p_edge_sel;
      bit_tick |-> TRANSMIT_LINE_CLOCK == s_q.tc.sample_edge_rise &&
         $past(TRANSMIT_LINE_CLOCK) != TRANSMIT_LINE_CLOCK;
   endproperty
   a_edge_sel: assert property (p_edge_sel)
      else $error("data sampled on the wrong clock edge");

   property p_e3_shape;
      E3_MODE |=> !PULSE_SHAPE_EN;
   endproperty
   a_e3_shape: assert property (p_e3_shape)
      else $error("pulse shaping enabled in E3 mode");
endmodule

// *** verif/ltcc_far.sv ***
// far-end line model: monitor tap wired to the line rails
// assumes rails are synchronous levels from the block under test
`timescale 1ns/1ps

module ltcc_far
(
   // line rails from the transmitter
   input wire logic line_plus,
   input wire logic line_minus,
   // fault control from the bench
   input wire logic cut,
   // monitor tap
   output logic mon_plus,
   output logic mon_minus
);
   // a cut tap falls to its pull-down, so no pulses reach the monitor
   assign mon_plus = cut ? 1'b0 : line_plus;
   assign mon_minus = cut ? 1'b0 : line_minus;
endmodule

// *** verif/ltcc_top_tb.sv ***
// self-checking bench for the tx channel control block
// assumes ltcc_pkg and the far-end model are compiled first
`timescale 1ns/1ps

module ltcc_top_tb;
   import ltcc_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   ltcc_bus_req_t bus = '0;
   logic [7:0] rd_data;
   logic tclk = 1'b0, tpos = 1'b0, tneg = 1'b0, cut = 1'b0;
   logic gen_en = 1'b0, rx_en = 1'b0, e3 = 1'b0, rd_seen = 1'b0;
   logic lp, lm, mp, mn, inj, shape, alarm, prev;
   logic [1:0] want;
   logic [7:0] q[$];
   logic [7:0] seed = 8'h2F;
   int miscompares = 0, check_count = 0, inj_cnt = 0, cycles = 0;

   always #12.5 clk = ~clk;

   ltcc_top dut_u (.CLK(clk), .RESET_N(reset_n), .BUS_REQ(bus),
      .RD_DATA(rd_data), .TRANSMIT_LINE_CLOCK(tclk),
      .TRANSMIT_POSITIVE_DATA(tpos), .TRANSMIT_NEGATIVE_DATA(tneg),
      .LINE_OUT_PLUS(lp), .LINE_OUT_MINUS(lm), .MONITOR_IN_PLUS(mp),
      .MONITOR_IN_MINUS(mn), .PRBS_GEN_EN(gen_en), .PRBS_RX_EN(rx_en),
      .E3_MODE(e3), .PRBS_ERR_INJECT(inj), .PULSE_SHAPE_EN(shape),
      .DRIVE_MONITOR_ALARM(alarm));

   ltcc_far far_u (.line_plus(lp), .line_minus(lm), .cut(cut),
      .mon_plus(mp), .mon_minus(mn));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask

   // the expected value is noted now, compared when the data appear
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      q.push_back(exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
   endtask

   // one bit: low half carries v[1:0], high half v[3:2]
   task automatic bitp(input logic [3:0] v);
      @(posedge clk);
      tclk <= 1'b0;
      tpos <= v[0];
      tneg <= v[1];
      repeat (2) @(posedge clk);
      tclk <= 1'b1;
      tpos <= v[2];
      tneg <= v[3];
      repeat (2) @(posedge clk);
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   always @(posedge clk)
   begin
      cycles++;
      if (inj === 1'b1)
         inj_cnt++;
      if (rd_seen)
         check(rd_data, q.pop_front());
      rd_seen <= bus.rd;
      if (cycles == 20000)
      begin
         miscompares++;
         finish_test();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      // reset value, reserved bits, unmapped place
      rd(8'h04, 8'h00);
      wr(8'h04, 8'hCA);
      rd(8'h04, 8'h02);
      wr(8'h21, 8'hFF);
      rd(8'h21, 8'h00);
      rd(8'h04, 8'h02);
      // data changes between edges, so the wrong edge shows
      for (int e = 1; e >= 0; e--)
      begin
         wr(8'h04, {6'd0, e[0], 1'b0});
         repeat (4)
         begin
            seed = lfsr(seed);
            bitp(seed[3:0]);
            // plus rail carries the even bit, minus rail the odd one
            want = e ? {seed[2], seed[3]} : {seed[0], seed[1]};
            check({lp, lm}, want);
         end
      end
      // all ones ignores the zero system data
      // alternation starts with the plus rail low after reset
      wr(8'h04, 8'h04);
      prev = 1'b0;
      repeat (3)
      begin
         bitp(4'h0);
         check({lp, lm}, {prev, ~prev});
         prev = ~prev;
      end
      // error insert: one pulse per 0-to-1 edge, none once PRBS receive is off
      gen_en <= 1'b1;
      rx_en <= 1'b1;
      wr(8'h04, 8'h10);
      bitp(4'h0);
      bitp(4'h0);
      check(inj_cnt[7:0], 8'd1);
      wr(8'h04, 8'h10);
      bitp(4'h0);
      check(inj_cnt[7:0], 8'd1);
      wr(8'h04, 8'h00);
      wr(8'h04, 8'h10);
      bitp(4'h0);
      check(inj_cnt[7:0], 8'd2);
      rx_en <= 1'b0;
      wr(8'h04, 8'h00);
      wr(8'h04, 8'h10);
      bitp(4'h0);
      check(inj_cnt[7:0], 8'd2);
      // external monitor through the tap, then the tap cut
      wr(8'h04, 8'h00);
      bitp(4'h1);
      bitp(4'h1);
      check({7'd0, alarm}, 8'd0);
      cut <= 1'b1;
      repeat (127) bitp(4'h1);
      check({7'd0, alarm}, 8'd0);
      bitp(4'h1);
      check({7'd0, alarm}, 8'd1);
      // internal monitor sees the pads although the tap is still cut
      wr(8'h04, 8'h20);
      bitp(4'h1);
      check({7'd0, alarm}, 8'd0);
      repeat (129) bitp(4'h0);
      check({7'd0, alarm}, 8'd1);
      rd(8'h0F, 8'h01);
      // shaping is dropped in E3 mode
      wr(8'h04, 8'h01);
      repeat (2) @(posedge clk);
      #1 check({7'd0, shape}, 8'd1);
      e3 <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check({7'd0, shape}, 8'd0);
      repeat (3) @(posedge clk);
      finish_test();
   end
endmodule
